// file: src/rpsm_pkg.sv
// Purpose: Shared constants and types for the remappable pin-select matrix.
// Assumes: AXI4-Lite register access with 32-bit data, one word per register.
// Notes: Register offsets are byte addresses chosen for this block.
package rpsm_pkg;
    localparam int unsigned SEL_W = 6;
    localparam int unsigned NUM_PINS = 64;
    localparam int unsigned NUM_OUT_PINS = 12;
    localparam int unsigned NUM_FUNCS = 64;
    localparam int unsigned NUM_OUT_REGS = 6;
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned REG_W = 16;
    localparam int unsigned LO_LSB = 0;
    localparam int unsigned HI_LSB = 8;
    localparam logic [ADDR_W-1:0] OFS_SPI_C_CLK_DATA = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_SPI_C_SS = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_OUT_BASE = 8'h10;
    localparam logic [SEL_W-1:0] IN_SEL_RESET = 6'h3F;
    localparam logic [SEL_W-1:0] OUT_SEL_RESET = 6'h00;
    localparam logic [SEL_W-1:0] OUT_SEL_NONE = 6'h00;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic clk_in;
        logic data_in;
        logic ss_in;
    } rpsm_spi_in_s;

    typedef struct packed {
        logic [REG_W-1:0] data;
        logic err;
    } rpsm_rd_s;
endpackage

// file: src/rpsm_sel_store.sv
// Purpose: Holds the twelve output-select fields, read data registered.
// Assumes: One write port and one read port, both word indexed.
// Notes: Reset clears every field so no remapped function owns a pin.
module rpsm_sel_store (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire logic wr_en,
    input wire logic [2:0] wr_idx,
    input wire logic [1:0] wr_strb,
    input wire logic [11:0] wr_data,
    input wire logic [2:0] rd_idx,
    output logic [11:0] rd_data_ff,
    output logic [rpsm_pkg::NUM_OUT_PINS*rpsm_pkg::SEL_W-1:0] sel_flat
);
    logic [rpsm_pkg::SEL_W-1:0] mem_ff [rpsm_pkg::NUM_OUT_PINS];

    genvar gi;
    generate
        for (gi = 0; gi < rpsm_pkg::NUM_OUT_PINS; gi++)
        begin : g_fld
            always_ff @(posedge sys_clk or negedge rst_n)
            begin
                if (!rst_n)
                    mem_ff[gi] <= rpsm_pkg::OUT_SEL_RESET;
                else if (clk_en && wr_en && (wr_idx == 3'(gi / 2))
                         && wr_strb[gi % 2])
                    mem_ff[gi] <= wr_data[(gi%2)*6 +: 6];
            end
            assign sel_flat[gi*6 +: 6] = mem_ff[gi];
        end
    endgenerate

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            rd_data_ff <= 12'h000;
        else if (clk_en && (rd_idx < 3'(rpsm_pkg::NUM_OUT_REGS)))
            rd_data_ff <= {mem_ff[{rd_idx, 1'b1}], mem_ff[{rd_idx, 1'b0}]};
    end
endmodule

// file: src/rpsm_matrix.sv
// Purpose: Remappable pin-select matrix slice with an AXI4-Lite slave.
// Assumes: Pin and peripheral signals are synchronous to sys_clk.
// Notes: Routed signals are registered, so they lag the pins by one cycle.
// Contract
// - Clock-select field bits 13-8 routes a pin to the third port clock.
// - Data-select field bits 5-0 routes a pin to the third port data.
// - Slave-select field bits 5-0 routes a pin to slave select.
// - Reset sets input-select bits to one, clears output-select bits.
// - Unimplemented bits read back as zero in every select register.
// - Implemented bits are read and written, reads return the held value.
// - Output field value n drives its pin with peripheral output n; here value zero holds the pin low instead.
// - Six output registers, even pin at 5-0, odd pin at 13-8.
//
// Decided for this implementation: the AXI4-Lite register port and the register offsets.
module rpsm_matrix (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic clk_en,
    input wire logic [rpsm_pkg::NUM_PINS-1:0] pin_in,
    input wire logic [rpsm_pkg::NUM_FUNCS-1:0] periph_out,
    output rpsm_pkg::rpsm_spi_in_s spi_c_in_ff,
    output logic [rpsm_pkg::NUM_OUT_PINS-1:0] pin_out_ff,
    output logic [rpsm_pkg::NUM_OUT_PINS-1:0] pin_remap_ff,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    typedef enum logic [2:0] {
        RD_IDLE = 3'b001,
        RD_WAIT = 3'b010,
        RD_RESP = 3'b100
    } rpsm_rd_e;

    logic [rpsm_pkg::SEL_W-1:0] clk_sel_ff;
    logic [rpsm_pkg::SEL_W-1:0] data_sel_ff;
    logic [rpsm_pkg::SEL_W-1:0] ss_sel_ff;
    logic [7:0] aw_addr_ff;
    logic aw_held_ff;
    logic [31:0] w_data_ff;
    logic [3:0] w_strb_ff;
    logic w_held_ff;
    logic [7:0] ar_addr_ff;
    logic rd_store_ff;
    logic [15:0] rd_local_ff;
    logic rd_err_ff;
    rpsm_rd_e rd_state_ff;
    logic do_write;
    logic wr_out;
    logic [2:0] wr_idx;
    logic [2:0] rd_idx;
    logic [11:0] store_rd;
    logic [rpsm_pkg::NUM_OUT_PINS*rpsm_pkg::SEL_W-1:0] out_sel;

    // Decode an offset to an output-register index; 7 means not an output.
    function automatic logic [2:0] out_index(input logic [7:0] addr);
        logic [7:0] rel;
        rel = addr - rpsm_pkg::OFS_OUT_BASE;
        if (addr < rpsm_pkg::OFS_OUT_BASE)
            out_index = 3'h7;
        else if (rel[1:0] != 2'h0)
            out_index = 3'h7;
        else if (rel[7:2] >= 6'(rpsm_pkg::NUM_OUT_REGS))
            out_index = 3'h7;
        else
            out_index = rel[4:2];
    endfunction

    assign do_write = aw_held_ff && w_held_ff && !s_axi_bvalid;
    assign wr_idx = out_index(aw_addr_ff);
    assign wr_out = do_write && (wr_idx != 3'h7);
    assign rd_idx = out_index(ar_addr_ff);

    // Write channels are taken independently, then joined.
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            aw_held_ff <= 1'b0;
            aw_addr_ff <= 8'h00;
            s_axi_awready <= 1'b0;
        end
        else if (clk_en)
        begin
            s_axi_awready <= !aw_held_ff && !s_axi_awready;
            if (s_axi_awvalid && s_axi_awready)
            begin
                aw_held_ff <= 1'b1;
                aw_addr_ff <= s_axi_awaddr;
            end
            else if (do_write)
                aw_held_ff <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            w_held_ff <= 1'b0;
            w_data_ff <= 32'h0000_0000;
            w_strb_ff <= 4'h0;
            s_axi_wready <= 1'b0;
        end
        else if (clk_en)
        begin
            s_axi_wready <= !w_held_ff && !s_axi_wready;
            if (s_axi_wvalid && s_axi_wready)
            begin
                w_held_ff <= 1'b1;
                w_data_ff <= s_axi_wdata;
                w_strb_ff <= s_axi_wstrb;
            end
            else if (do_write)
                w_held_ff <= 1'b0;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= rpsm_pkg::RESP_OKAY;
        end
        else if (clk_en)
        begin
            if (do_write)
            begin
                s_axi_bvalid <= 1'b1;
                if (wr_out || aw_addr_ff == rpsm_pkg::OFS_SPI_C_CLK_DATA ||
                    aw_addr_ff == rpsm_pkg::OFS_SPI_C_SS)
                    s_axi_bresp <= rpsm_pkg::RESP_OKAY;
                else
                    s_axi_bresp <= rpsm_pkg::RESP_SLVERR;
            end
            else if (s_axi_bready)
                s_axi_bvalid <= 1'b0;
        end
    end

    // Input-select fields; reset to all ones selects pin 63, the last real pin.
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            clk_sel_ff <= rpsm_pkg::IN_SEL_RESET;
            data_sel_ff <= rpsm_pkg::IN_SEL_RESET;
            ss_sel_ff <= rpsm_pkg::IN_SEL_RESET;
        end
        else if (clk_en && do_write)
        begin
            if (aw_addr_ff == rpsm_pkg::OFS_SPI_C_CLK_DATA)
            begin
                if (w_strb_ff[1])
                    clk_sel_ff <= w_data_ff[rpsm_pkg::HI_LSB +: 6];
                if (w_strb_ff[0])
                    data_sel_ff <= w_data_ff[rpsm_pkg::LO_LSB +: 6];
            end
            else if (aw_addr_ff == rpsm_pkg::OFS_SPI_C_SS)
            begin
                if (w_strb_ff[0])
                    ss_sel_ff <= w_data_ff[rpsm_pkg::LO_LSB +: 6];
            end
        end
    end

    rpsm_sel_store u_store (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .clk_en(clk_en),
        .wr_en(wr_out),
        .wr_idx(wr_idx),
        .wr_strb(w_strb_ff[1:0]),
        .wr_data({w_data_ff[13:8], w_data_ff[5:0]}),
        .rd_idx(rd_idx),
        .rd_data_ff(store_rd),
        .sel_flat(out_sel)
    );

    // Reads take one extra cycle so the store's registered data is ready.
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rd_state_ff <= RD_IDLE;
            ar_addr_ff <= 8'h00;
            s_axi_arready <= 1'b0;
            rd_store_ff <= 1'b0;
            rd_local_ff <= 16'h0000;
            rd_err_ff <= 1'b0;
        end
        else if (clk_en)
        begin
            case (rd_state_ff)
                RD_IDLE:
                begin
                    s_axi_arready <= !s_axi_arready;
                    if (s_axi_arvalid && s_axi_arready)
                    begin
                        s_axi_arready <= 1'b0;
                        ar_addr_ff <= s_axi_araddr;
                        rd_state_ff <= RD_WAIT;
                    end
                end
                RD_WAIT:
                begin
                    rd_store_ff <= rd_idx != 3'h7;
                    rd_err_ff <= 1'b0;
                    if (ar_addr_ff == rpsm_pkg::OFS_SPI_C_CLK_DATA)
                        rd_local_ff <= {2'b00, clk_sel_ff, 2'b00, data_sel_ff};
                    else if (ar_addr_ff == rpsm_pkg::OFS_SPI_C_SS)
                        rd_local_ff <= {10'h000, ss_sel_ff};
                    else
                    begin
                        rd_local_ff <= 16'h0000;
                        rd_err_ff <= rd_idx == 3'h7;
                    end
                    rd_state_ff <= RD_RESP;
                end
                RD_RESP:
                begin
                    if (s_axi_rvalid && s_axi_rready)
                        rd_state_ff <= RD_IDLE;
                end
                default:
                    rd_state_ff <= RD_IDLE;
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= rpsm_pkg::RESP_OKAY;
        end
        else if (clk_en)
        begin
            if (rd_state_ff == RD_RESP && !s_axi_rvalid)
            begin
                s_axi_rvalid <= 1'b1;
                if (rd_store_ff)
                    s_axi_rdata <= {16'h0000, 2'b00, store_rd[11:6],
                                    2'b00, store_rd[5:0]};
                else
                    s_axi_rdata <= {16'h0000, rd_local_ff};
                s_axi_rresp <= rd_err_ff ? rpsm_pkg::RESP_SLVERR :
                               rpsm_pkg::RESP_OKAY;
            end
            else if (s_axi_rvalid && s_axi_rready)
                s_axi_rvalid <= 1'b0;
        end
    end

    // Every select value picks one of the 64 pins; reset loads all ones, idle high.
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            spi_c_in_ff <= '1;
        else if (clk_en)
        begin
            spi_c_in_ff.clk_in <= pin_in[clk_sel_ff];
            spi_c_in_ff.data_in <= pin_in[data_sel_ff];
            spi_c_in_ff.ss_in <= pin_in[ss_sel_ff];
        end
    end

    genvar gp;
    generate
        for (gp = 0; gp < rpsm_pkg::NUM_OUT_PINS; gp++)
        begin : g_pin
            always_ff @(posedge sys_clk or negedge rst_n)
            begin
                if (!rst_n)
                begin
                    pin_out_ff[gp] <= 1'b0;
                    pin_remap_ff[gp] <= 1'b0;
                end
                else if (clk_en)
                begin
                    // drive function n
                    // Value zero gates the function off so the pin stays low.
                    pin_out_ff[gp] <=
                        (out_sel[gp*6 +: 6] != rpsm_pkg::OUT_SEL_NONE)
                        && periph_out[out_sel[gp*6 +: 6]];
                    pin_remap_ff[gp] <=
                        out_sel[gp*6 +: 6] != rpsm_pkg::OUT_SEL_NONE;
                end
            end
        end
    endgenerate
endmodule

// file: testbench/rpsm_assertions.sv
// Purpose: Port-level checks for the remappable pin-select matrix.
// Assumes: One clock domain, asynchronous active-low reset.
// Notes: The read address is kept so a read can be judged by register.
module rpsm_assertions (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire rpsm_pkg::rpsm_spi_in_s spi_c_in_ff,
    input wire logic [11:0] pin_out_ff,
    input wire logic [11:0] pin_remap_ff
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] ar_q_ff;
    always_ff @(posedge sys_clk or negedge rst_n)
        if (!rst_n)
            ar_q_ff <= 8'h00;
        else if (s_axi_arvalid && s_axi_arready)
            ar_q_ff <= s_axi_araddr;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    sequence ar_taken; s_axi_arvalid && s_axi_arready; endsequence
    sequence r_taken; s_axi_rvalid && s_axi_rready; endsequence
    sequence b_taken; s_axi_bvalid && s_axi_bready; endsequence
    reset_values_a:
        assert property ($rose(rst_n) |-> spi_c_in_ff == 3'h7
            && pin_out_ff == 12'h000 && pin_remap_ff == 12'h000)
        else $error("Outputs not at reset values after reset.");
    reserved_zero_a:
        assert property (s_axi_rvalid |-> s_axi_rdata[31:14] == 18'h0
            && s_axi_rdata[7:6] == 2'h0)
        else $error("Unimplemented bits read as nonzero.");
    ss_upper_zero_a:
        assert property (s_axi_rvalid && ar_q_ff == rpsm_pkg::OFS_SPI_C_SS
            |-> s_axi_rdata[15:6] == 10'h0)
        else $error("Slave-select register upper bits nonzero.");
    err_data_zero_a:
        assert property (s_axi_rvalid && s_axi_rresp == rpsm_pkg::RESP_SLVERR
            |-> s_axi_rdata == 32'h0)
        else $error("Refused read returned data.");
    read_latency_a:
        assert property (ar_taken |=> !s_axi_rvalid ##1 !s_axi_rvalid
            ##1 s_axi_rvalid)
        else $error("Read data late.");
    read_once_a:
        assert property (r_taken |=> !s_axi_rvalid)
        else $error("Read data repeated.");
    write_once_a:
        assert property (b_taken |=> !s_axi_bvalid)
        else $error("Write response repeated.");
    remap_owner_a:
        assert property ((pin_out_ff & ~pin_remap_ff) == 12'h000)
        else $error("Unmapped pin driven by a function.");
    remap_after_wr_a:
        assert property ($changed(pin_remap_ff)
            |-> $past(s_axi_bvalid) || $past(s_axi_bvalid, 2))
        else $error("Pin ownership changed without a write.");
endmodule

// file: testbench/rpsm_far_side.sv
// Purpose: Pin levels and peripheral outputs facing the matrix.
// Assumes: Levels are static between edges, driven from flip.
// Notes: Flip inverts all levels so every routed bit is seen both ways.
module rpsm_far_side #(
    parameter logic [63:0] PIN_PAT = 64'h0,
    parameter logic [63:0] FN_PAT = 64'h0
) (
    input wire logic flip,
    output logic [63:0] pin_in,
    output logic [63:0] periph_out
);
    timeunit 1ns;
    timeprecision 1ps;
    assign periph_out = flip ? ~FN_PAT : FN_PAT;
    assign pin_in = flip ? ~PIN_PAT : PIN_PAT;
endmodule

// file: testbench/tb_remappable_pin_select_matrix.sv
// Purpose: Self-checking bench for the remappable pin-select matrix.
// Assumes: AXI4-Lite master tasks; bready and rready stay high.
// Notes: Far-side levels are static, so routed values are exact.
module tb_remappable_pin_select_matrix;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [63:0] PP = 64'h8F3C_5A96_0FF0_C3A5;
    localparam logic [63:0] FP = 64'h6D2B_94E1_3C78_A5D2;
    localparam logic [1:0] OK = rpsm_pkg::RESP_OKAY;
    localparam logic [1:0] BAD = rpsm_pkg::RESP_SLVERR;
    localparam logic [7:0] OB = rpsm_pkg::OFS_OUT_BASE;
    logic sys_clk = 1'b0, rst_n = 1'b0, clk_en = 1'b1, flip = 1'b0;
    logic [63:0] pin_in, periph_out;
    rpsm_pkg::rpsm_spi_in_s spi_c_in_ff;
    logic [11:0] pin_out_ff, pin_remap_ff;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
    logic s_axi_bready = 1'b1, s_axi_rready = 1'b1;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    int n_mismatch = 0, num_checks = 0, cyc = 0;
    rpsm_matrix i_rpsm_matrix (.*);
    rpsm_far_side #(.PIN_PAT(PP), .FN_PAT(FP)) i_rpsm_far_side (.*);
    initial
    begin
        forever #2 sys_clk = ~sys_clk;
    end
    // A hang is cut short well past the few hundred cycles needed.
    always @(posedge sys_clk)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            n_mismatch++;
            wrap_up();
        end
    end
    task automatic wrap_up();
        if (n_mismatch == 0 && num_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        num_checks++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      input logic [1:0] r);
        logic aw, w;
        aw = 1'b1;
        w = 1'b1;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        while (aw || w)
        begin
            @(posedge sys_clk);
            aw = aw && s_axi_awready !== 1'b1;
            w = w && s_axi_wready !== 1'b1;
            s_axi_awvalid <= aw;
            s_axi_wvalid <= w;
        end
        do @(posedge sys_clk); while (s_axi_bvalid !== 1'b1);
        chk({30'h0, s_axi_bresp}, {30'h0, r});
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e,
                      input logic [1:0] r);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do @(posedge sys_clk); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        do @(posedge sys_clk); while (s_axi_rvalid !== 1'b1);
        chk(s_axi_rdata, e);
        chk({30'h0, s_axi_rresp}, {30'h0, r});
    endtask
    initial
    begin
        logic [63:0] p, f;
        logic [5:0] lo, hi;
        logic [7:0] a;
        repeat (12) @(posedge sys_clk);
        rst_n <= 1'b1;
        @(posedge sys_clk);
        rd(8'h00, 32'h3F3F, OK);
        rd(8'h04, 32'h3F, OK);
        for (int k = 0; k < 6; k++)
            rd(OB + 8'(4 * k), 32'h0, OK);
        chk({29'h0, spi_c_in_ff}, 32'h7);
        wr(8'h00, 32'h0C05, OK);
        wr(8'h04, 32'h27, OK);
        for (int k = 0; k < 6; k++)
        begin
            lo = 6'(7 * k + 3);
            hi = 6'(5 * k + 33);
            wr(OB + 8'(4 * k), {18'h0, hi, 2'h0, lo}, OK);
            rd(OB + 8'(4 * k), {18'h0, hi, 2'h0, lo}, OK);
        end
        for (int v = 0; v < 2; v++)
        begin
            flip <= 1'(v);
            repeat (3) @(posedge sys_clk);
            p = (v == 1) ? ~PP : PP;
            f = (v == 1) ? ~FP : FP;
            chk({29'h0, spi_c_in_ff}, {29'h0, p[12], p[5], p[39]});
            for (int k = 0; k < 6; k++)
            begin
                chk({31'h0, pin_out_ff[2 * k]}, {31'h0, f[7 * k + 3]});
                chk({31'h0, pin_out_ff[2 * k + 1]}, {31'h0, f[5 * k + 33]});
            end
            chk({20'h0, pin_remap_ff}, 32'hFFF);
        end
        wr(OB, 32'h2100, OK);
        repeat (3) @(posedge sys_clk);
        chk({31'h0, pin_out_ff[0]}, 32'h0);
        chk({20'h0, pin_remap_ff}, 32'hFFE);
        for (int k = 0; k < 8; k++)
        begin
            a = (k < 2) ? 8'(4 * k) : 8'(4 * k + 8);
            wr(a, 32'hFFFF_FFFF, OK);
            rd(a, (k == 1) ? 32'h3F : 32'h3F3F, OK);
        end
        wr(8'h08, 32'hFFFF_FFFF, BAD);
        rd(8'h08, 32'h0, BAD);
        repeat (3) @(posedge sys_clk);
        chk({29'h0, spi_c_in_ff}, {29'h0, {3{~PP[63]}}});
        chk({20'h0, pin_out_ff}, {20'h0, {12{~FP[63]}}});
        // Clock enable low must freeze the routed outputs.
        clk_en <= 1'b0;
        flip <= 1'b0;
        repeat (3) @(posedge sys_clk);
        chk({29'h0, spi_c_in_ff}, {29'h0, {3{~PP[63]}}});
        chk({20'h0, pin_out_ff}, {20'h0, {12{~FP[63]}}});
        clk_en <= 1'b1;
        repeat (3) @(posedge sys_clk);
        chk({29'h0, spi_c_in_ff}, {29'h0, {3{PP[63]}}});
        chk({20'h0, pin_out_ff}, {20'h0, {12{FP[63]}}});
        // A low-byte strobe alone must leave the odd pin field intact.
        s_axi_wstrb <= 4'h1;
        wr(OB, 32'h0, OK);
        s_axi_wstrb <= 4'hF;
        rd(OB, 32'h3F00, OK);
        repeat (3) @(posedge sys_clk);
        chk({20'h0, pin_remap_ff}, 32'hFFE);
        chk({31'h0, pin_out_ff[0]}, 32'h0);
        wrap_up();
    end
endmodule
bind rpsm_matrix rpsm_assertions i_rpsm_assertions (.*);
